// >>> hw/host_port_if.sv
`timescale 1ns/10ps
interface host_port_if;
    import host_port_pkg::*;

    logic [NPINS-1:0] dev_o;
    logic [NPINS-1:0] dev_oe;
    logic [NPINS-1:0] host_o;
    logic [NPINS-1:0] host_oe;
    logic [NPINS-1:0] lvl;
    logic             strap_o;
    logic             strap_oe;
    logic             strap;
    logic             usb_dp_pullup;

    // wired-and with board pull-ups; an undriven pin reads high
    for (genvar i = 0; i < NPINS; i++) begin : g_pin
        assign lvl[i] = (dev_oe[i] ? dev_o[i] : 1'b1) & (host_oe[i] ? host_o[i] : 1'b1);
    end
    assign strap = strap_oe ? strap_o : STRAP_UART;

    modport dev  (input lvl, strap, output dev_o, dev_oe, usb_dp_pullup);
    modport host (input lvl, usb_dp_pullup, output host_o, host_oe, strap_o, strap_oe);

endinterface

// >>> hw/host_port_pkg.sv
package host_port_pkg;

    // ----------------------------------------
    // clock and link rates
    // ----------------------------------------
    localparam int CLK_HZ       = 100_000_000;
    localparam int SPI_MAX_HZ   = 5_500_000;
    localparam int SPI_MAX_BPS  = 1_000_000;
    localparam int TW_MAX_HZ    = 400_000;
    localparam int USB_FS_BPS   = 12_000_000;

    // least half periods round up, so the clocks never run fast
    localparam int SPI_HALF_I   = (CLK_HZ + 2 * SPI_MAX_HZ - 1) / (2 * SPI_MAX_HZ);
    localparam int SPI_BYTE_I   = (8 * CLK_HZ + SPI_MAX_BPS - 1) / SPI_MAX_BPS;
    localparam int TW_HALF_I    = (CLK_HZ + 2 * TW_MAX_HZ - 1) / (2 * TW_MAX_HZ);

    localparam int CNT_W        = 16;
    typedef logic [CNT_W-1:0] cnt_t;

    localparam cnt_t SPI_HALF   = cnt_t'(SPI_HALF_I);
    localparam cnt_t SPI_BYTE   = cnt_t'(SPI_BYTE_I);
    localparam cnt_t TW_HALF    = cnt_t'(TW_HALF_I);
    localparam cnt_t TW_MID     = cnt_t'(TW_HALF_I / 2);
    localparam cnt_t CNT_ONE    = 16'h0001;

    // ----------------------------------------
    // shared pins and strap
    // ----------------------------------------
    localparam int NPINS        = 4;
    localparam int PIN_TXD      = 0;    // uart tx  / spi miso
    localparam int PIN_RXD      = 1;    // uart rx  / spi mosi
    localparam int PIN_CLK      = 2;    // tw clock / spi clock
    localparam int PIN_DAT      = 3;    // tw data  / spi cs_n
    localparam int SYNC_STRAP   = 4;
    localparam int SYNC_W       = 5;

    localparam logic              STRAP_UART   = 1'b1;
    localparam logic [SYNC_W-1:0] SYNC_IDLE    = 5'h1f;
    localparam logic [1:0]        STRAP_SETTLE = 2'h2;

    // ----------------------------------------
    // byte framing
    // ----------------------------------------
    localparam logic [2:0] BIT_LAST   = 3'h7;
    localparam logic [3:0] UART_STOP  = 4'h9;
    localparam logic [9:0] UART_IDLE  = 10'h3ff;

endpackage

// >>> hw/port_select_dev.sv
`timescale 1ns/10ps
// How it works
// - strap high or open selects uart and two-wire
// - strap tied low selects the spi slave
// - fixed pin order per selected mode
// - spi mode disables two-wire data port
// - spi is slave only, host clocks
// - host keeps spi clock, rate limits
// - two-wire is fast-mode slave, host 400 khz
// - slave stretches clock while busy
// - usb full speed with d+ pull-up
// - uart baud rate set by configuration
// - uart and spi carry whole bytes, two-wire only pin levels, usb only the pull-up
module port_select_dev (
    input  wire logic                  clk_i,           // system clock
    input  wire logic                  srst_i,          // sync reset
    host_port_if.dev                   pins,            // shared pins and strap
    input  wire host_port_pkg::cnt_t   baud_div_i,      // clocks per uart bit
    input  wire logic                  uart_tx_valid_i, // byte to send
    input  wire logic [7:0]            uart_tx_data_i,  // uart tx byte
    output      logic                  uart_tx_ready_o, // may take a byte
    output      logic                  uart_rx_valid_o, // received byte pulse
    output      logic [7:0]            uart_rx_data_o,  // received byte
    input  wire logic [7:0]            spi_tx_data_i,   // next miso byte
    output      logic                  spi_rx_valid_o,  // mosi byte pulse
    output      logic [7:0]            spi_rx_data_o,   // mosi byte
    output      logic                  tw_scl_o,        // two-wire clock level
    output      logic                  tw_sda_o,        // two-wire data level
    input  wire logic                  tw_sda_low_i,    // pull data low
    input  wire logic                  tw_busy_i,       // stretch the clock
    output      logic                  mode_valid_o,    // selection made
    output      logic                  spi_mode_o       // 1 spi, 0 uart and two-wire
);
    import host_port_pkg::*;

    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [1:0]        settle;
        logic              mode_valid;
        logic              spi_mode;
        logic              tx_busy;
        logic [9:0]        tx_shift;
        cnt_t              tx_cnt;
        logic [3:0]        tx_bits;
        logic              tx_ready;
        logic              rx_busy;
        cnt_t              rx_cnt;
        logic [3:0]        rx_bits;
        logic [7:0]        rx_shift;
        logic              rx_valid;
        logic [7:0]        rx_data;
        logic              sclk_prev;
        logic [2:0]        spi_bits;
        logic [7:0]        spi_in;
        logic [7:0]        spi_out;
        logic              spi_valid;
        logic [7:0]        spi_data;
        logic              stretch;
        logic              scl;
        logic              sda;
        logic [NPINS-1:0]  pin_o;
        logic [NPINS-1:0]  pin_oe;
        logic              dp_pullup;
    } dev_s;

    dev_s st_reg;
    dev_s st_next;

    logic uart_en;
    logic spi_en;
    logic sclk;
    logic csn;
    logic rxd;

    // ----------------------------------------
    // mode latch and pin sampling
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.s1 = {pins.strap, pins.lvl};
        st_next.s2 = st_reg.s1;
        st_next.rx_valid = 1'b0;
        st_next.spi_valid = 1'b0;
        st_next.dp_pullup = 1'b1;

        // strap is read once the synchroniser holds real samples
        if (!st_reg.mode_valid) begin
            if (st_reg.settle == STRAP_SETTLE) begin
                st_next.mode_valid = 1'b1;
                st_next.spi_mode = (st_reg.s2[SYNC_STRAP] != STRAP_UART);
            end else begin
                st_next.settle = st_reg.settle + 2'h1;
            end
        end

        uart_en = st_reg.mode_valid & ~st_reg.spi_mode;
        spi_en  = st_reg.mode_valid & st_reg.spi_mode;
        rxd  = st_reg.s2[PIN_RXD];
        sclk = st_reg.s2[PIN_CLK];
        csn  = st_reg.s2[PIN_DAT];

        // ----------------------------------------
        // uart transmitter, bytes pass unchanged
        // ----------------------------------------
        if (st_reg.tx_busy) begin
            if (st_reg.tx_cnt == baud_div_i - CNT_ONE) begin
                st_next.tx_cnt = '0;
                st_next.tx_shift = {1'b1, st_reg.tx_shift[9:1]};
                st_next.tx_bits = st_reg.tx_bits + 4'h1;
                if (st_reg.tx_bits == UART_STOP) begin
                    st_next.tx_busy = 1'b0;
                end
            end else begin
                st_next.tx_cnt = st_reg.tx_cnt + CNT_ONE;
            end
        end else if (uart_en && st_reg.tx_ready && uart_tx_valid_i) begin
            st_next.tx_shift = {1'b1, uart_tx_data_i, 1'b0};
            st_next.tx_busy = 1'b1;
            st_next.tx_cnt = '0;
            st_next.tx_bits = '0;
        end
        st_next.tx_ready = uart_en & ~st_next.tx_busy;

        // ----------------------------------------
        // uart receiver, samples mid-bit
        // ----------------------------------------
        if (!st_reg.rx_busy) begin
            if (uart_en && !rxd) begin
                st_next.rx_busy = 1'b1;
                st_next.rx_cnt = baud_div_i >> 1;
                st_next.rx_bits = '0;
            end
        end else if (st_reg.rx_cnt != '0) begin
            st_next.rx_cnt = st_reg.rx_cnt - CNT_ONE;
        end else begin
            st_next.rx_cnt = baud_div_i - CNT_ONE;
            st_next.rx_bits = st_reg.rx_bits + 4'h1;
            if (st_reg.rx_bits == '0) begin
                // a glitch, not a start bit
                st_next.rx_busy = ~rxd;
            end else if (st_reg.rx_bits == UART_STOP) begin
                st_next.rx_busy = 1'b0;
                if (rxd) begin
                    st_next.rx_valid = 1'b1;
                    st_next.rx_data = st_reg.rx_shift;
                end
            end else begin
                st_next.rx_shift = {rxd, st_reg.rx_shift[7:1]};
            end
        end

        // ----------------------------------------
        // spi slave, mode 0, clocked by the host
        // ----------------------------------------
        st_next.sclk_prev = sclk;
        if (!spi_en || csn) begin
            st_next.spi_bits = '0;
            st_next.spi_out = spi_tx_data_i;
        end else if (sclk && !st_reg.sclk_prev) begin
            st_next.spi_in = {st_reg.spi_in[6:0], rxd};
            st_next.spi_bits = st_reg.spi_bits + 3'h1;
            if (st_reg.spi_bits == BIT_LAST) begin
                st_next.spi_valid = 1'b1;
                st_next.spi_data = {st_reg.spi_in[6:0], rxd};
            end
        end else if (!sclk && st_reg.sclk_prev) begin
            st_next.spi_out = (st_reg.spi_bits == '0) ? spi_tx_data_i
                                                      : {st_reg.spi_out[6:0], 1'b0};
        end

        // ----------------------------------------
        // two-wire slave pins
        // ----------------------------------------
        // stretch only grabs a clock that the host already pulled low
        st_next.stretch = uart_en & tw_busy_i & (st_reg.stretch | ~sclk);
        st_next.scl = uart_en ? sclk : 1'b1;
        st_next.sda = uart_en ? csn  : 1'b1;

        // ----------------------------------------
        // pin routing
        // ----------------------------------------
        st_next.pin_o  = '0;
        st_next.pin_oe = '0;
        if (uart_en) begin
            st_next.pin_o[PIN_TXD]  = st_next.tx_shift[0];
            st_next.pin_oe[PIN_TXD] = 1'b1;
            st_next.pin_oe[PIN_CLK] = st_next.stretch;
            st_next.pin_oe[PIN_DAT] = tw_sda_low_i;
        end else if (spi_en && !csn) begin
            st_next.pin_o[PIN_TXD]  = st_next.spi_out[7];
            st_next.pin_oe[PIN_TXD] = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_reg <= '0;
            st_reg.s1 <= SYNC_IDLE;
            st_reg.s2 <= SYNC_IDLE;
            st_reg.tx_shift <= UART_IDLE;
            st_reg.scl <= 1'b1;
            st_reg.sda <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pins.dev_o        = st_reg.pin_o;
    assign pins.dev_oe       = st_reg.pin_oe;
    assign pins.usb_dp_pullup = st_reg.dp_pullup;
    assign uart_tx_ready_o   = st_reg.tx_ready;
    assign uart_rx_valid_o   = st_reg.rx_valid;
    assign uart_rx_data_o    = st_reg.rx_data;
    assign spi_rx_valid_o    = st_reg.spi_valid;
    assign spi_rx_data_o     = st_reg.spi_data;
    assign tw_scl_o          = st_reg.scl;
    assign tw_sda_o          = st_reg.sda;
    assign mode_valid_o      = st_reg.mode_valid;
    assign spi_mode_o        = st_reg.spi_mode;

endmodule

// >>> hw/port_select_host.sv
`timescale 1ns/10ps
module port_select_host (
    input  wire logic                  clk_i,          // system clock
    input  wire logic                  srst_i,         // sync reset
    host_port_if.host                  pins,           // shared pins
    input  wire logic                  strap_uart_i,   // 1 leave strap open, 0 tie low
    input  wire logic                  spi_valid_i,    // byte to send
    input  wire logic [7:0]            spi_data_i,     // mosi byte
    output      logic                  spi_ready_o,    // may take a byte
    output      logic                  spi_rx_valid_o, // miso byte pulse
    output      logic [7:0]            spi_rx_data_o,  // miso byte
    input  wire logic                  tw_valid_i,     // two-wire op request
    input  wire logic                  tw_cond_i,      // 1 start/stop, 0 data bit
    input  wire logic                  tw_bit_i,       // bit, or 0 start / 1 stop
    output      logic                  tw_ready_o,     // may take an op
    output      logic                  tw_done_o,      // op finished pulse
    output      logic                  tw_rx_bit_o     // sda seen at clock high
);
    import host_port_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE, H_SPI_LOW, H_SPI_HIGH, H_SPI_END, H_TW_LOW, H_TW_WAIT, H_TW_HIGH
    } hstate_e;

    typedef struct packed {
        logic [NPINS-1:0] s1;
        logic [NPINS-1:0] s2;
        hstate_e          st;
        cnt_t             cnt;
        cnt_t             gap;
        logic [2:0]       bits;
        logic [7:0]       tx;
        logic [7:0]       rx;
        logic             cond;
        logic             bitv;
        logic             strap_low;
        logic [NPINS-1:0] pin_o;
        logic [NPINS-1:0] pin_oe;
        logic             spi_ready;
        logic             spi_rx_valid;
        logic [7:0]       spi_rx_data;
        logic             tw_ready;
        logic             tw_done;
        logic             tw_rx_bit;
    } hst_s;

    hst_s st_reg;
    hst_s st_next;

    always_comb begin
        st_next = st_reg;
        st_next.s1 = pins.lvl;
        st_next.s2 = st_reg.s1;
        st_next.spi_rx_valid = 1'b0;
        st_next.tw_done = 1'b0;
        st_next.strap_low = ~strap_uart_i;
        if (st_next.gap != SPI_BYTE) begin
            st_next.gap = st_reg.gap + CNT_ONE;
        end
        st_next.cnt = st_reg.cnt + CNT_ONE;
        case (st_reg.st)
            H_IDLE: begin
                st_next.cnt = '0;
                if (st_reg.spi_ready && spi_valid_i) begin
                    st_next.st = H_SPI_LOW;
                    st_next.tx = spi_data_i;
                    st_next.bits = '0;
                    st_next.gap = '0;
                    st_next.pin_o[PIN_DAT] = 1'b0;
                    st_next.pin_o[PIN_RXD] = spi_data_i[7];
                end else if (st_reg.tw_ready && tw_valid_i) begin
                    st_next.cond = tw_cond_i;
                    st_next.bitv = tw_bit_i;
                    // a condition starts with the opposite sda level
                    st_next.pin_oe[PIN_DAT] = ~(tw_cond_i ? ~tw_bit_i : tw_bit_i);
                    st_next.st = st_reg.pin_oe[PIN_CLK] ? H_TW_LOW : H_TW_WAIT;
                end
            end
            H_SPI_LOW: if (st_reg.cnt == SPI_HALF - CNT_ONE) begin
                st_next.rx = {st_reg.rx[6:0], st_reg.s2[PIN_TXD]};
                st_next.pin_o[PIN_CLK] = 1'b1;
                st_next.cnt = '0;
                st_next.st = H_SPI_HIGH;
            end
            H_SPI_HIGH: if (st_reg.cnt == SPI_HALF - CNT_ONE) begin
                st_next.pin_o[PIN_CLK] = 1'b0;
                st_next.tx = {st_reg.tx[6:0], 1'b0};
                st_next.pin_o[PIN_RXD] = st_reg.tx[6];
                st_next.bits = st_reg.bits + 3'h1;
                st_next.cnt = '0;
                st_next.st = (st_reg.bits == BIT_LAST) ? H_SPI_END : H_SPI_LOW;
            end
            H_SPI_END: if (st_reg.cnt == SPI_HALF - CNT_ONE) begin
                st_next.pin_o[PIN_DAT] = 1'b1;
                st_next.spi_rx_valid = 1'b1;
                st_next.spi_rx_data = st_reg.rx;
                st_next.st = H_IDLE;
            end
            H_TW_LOW: if (st_reg.cnt == TW_HALF - CNT_ONE) begin
                st_next.pin_oe[PIN_CLK] = 1'b0;
                st_next.st = H_TW_WAIT;
            end
            H_TW_WAIT: begin
                st_next.cnt = '0;
                if (st_reg.s2[PIN_CLK]) begin
                    st_next.st = H_TW_HIGH;
                end
            end
            H_TW_HIGH: begin
                if (st_reg.cond && st_reg.cnt == TW_MID) begin
                    st_next.pin_oe[PIN_DAT] = ~st_reg.bitv;
                end
                if (st_reg.cnt == TW_HALF - CNT_ONE) begin
                    st_next.tw_rx_bit = st_reg.s2[PIN_DAT];
                    st_next.tw_done = 1'b1;
                    // after a stop the clock stays released
                    st_next.pin_oe[PIN_CLK] = ~(st_reg.cond & st_reg.bitv);
                    st_next.st = H_IDLE;
                end
            end
            default: st_next.st = H_IDLE;
        endcase
        if (st_next.strap_low) begin
            st_next.pin_oe[PIN_RXD] = 1'b1;
            st_next.pin_oe[PIN_TXD] = 1'b0;
            st_next.pin_oe[PIN_CLK] = 1'b1;
            st_next.pin_oe[PIN_DAT] = 1'b1;
        end else begin
            st_next.pin_o = '0;                         // two-wire pins open-drain
            st_next.pin_oe[PIN_RXD] = 1'b0;
            st_next.pin_oe[PIN_TXD] = 1'b0;
        end
        st_next.spi_ready = (st_next.st == H_IDLE) && st_next.strap_low
                            && (st_next.gap == SPI_BYTE);
        st_next.tw_ready = (st_next.st == H_IDLE) && !st_next.strap_low;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_reg <= '0;
            st_reg.s1 <= '1;
            st_reg.s2 <= '1;
            st_reg.gap <= SPI_BYTE;
            st_reg.pin_o <= '1;
            // mode 0 clock idles low, cs_n idles high
            st_reg.pin_o[PIN_CLK] <= 1'b0;
            // strap stays tied through reset, so the device samples a settled level
            st_reg.strap_low <= ~strap_uart_i;
            st_reg.st <= H_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pins.host_o     = st_reg.pin_o;
    assign pins.host_oe    = st_reg.pin_oe;
    assign pins.strap_o    = 1'b0;
    assign pins.strap_oe   = st_reg.strap_low;
    assign spi_ready_o     = st_reg.spi_ready;
    assign spi_rx_valid_o  = st_reg.spi_rx_valid;
    assign spi_rx_data_o   = st_reg.spi_rx_data;
    assign tw_ready_o      = st_reg.tw_ready;
    assign tw_done_o       = st_reg.tw_done;
    assign tw_rx_bit_o     = st_reg.tw_rx_bit;

endmodule

// >>> tb/host_port_select_checker.sv
`timescale 1ns/10ps
module host_port_select_checker (
    input wire logic                             clk_i,         // system clock
    input wire logic                             srst_i,        // sync reset
    input wire logic [host_port_pkg::NPINS-1:0] dev_o,         // device drive
    input wire logic [host_port_pkg::NPINS-1:0] dev_oe,        // device enable
    input wire logic [host_port_pkg::NPINS-1:0] lvl,           // pin levels
    input wire logic                             strap,         // strap level
    input wire logic                             usb_dp_pullup  // d+ pull-up
);
    import host_port_pkg::*;
    logic spi_sel_reg;
    cnt_t gap_reg;

    // mode copied from the strap while reset holds, gap counts since cs_n fell
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            spi_sel_reg <= ~strap;
            gap_reg     <= 16'hffff;
        end else if ($fell(lvl[PIN_DAT])) begin
            gap_reg <= 16'h0000;
        end else if (gap_reg != 16'hffff) begin
            gap_reg <= gap_reg + CNT_ONE;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    a_pullup_on: assert property (!srst_i |=> usb_dp_pullup)
        else $error("usb pull-up missing");
    a_reset_quiet: assert property ($fell(srst_i) |-> dev_oe == 4'h0 [*3])
        else $error("pin driven before selection");
    a_rx_input: assert property (dev_oe[PIN_RXD] == 1'b0)
        else $error("receive pin driven");
    a_slave_inputs: assert property (spi_sel_reg |-> dev_oe[3:1] == 3'h0)
        else $error("spi slave drives host pins");
    a_miso_idle: assert property (spi_sel_reg && lvl[PIN_DAT] [*4] |-> !dev_oe[PIN_TXD])
        else $error("miso driven without select");
    a_spi_clk_high: assert property (spi_sel_reg && $rose(lvl[PIN_CLK]) |-> lvl[PIN_CLK] [*8])
        else $error("spi clock high too short");
    a_spi_clk_low: assert property (spi_sel_reg && $fell(lvl[PIN_CLK]) |-> !lvl[PIN_CLK] [*8])
        else $error("spi clock low too short");
    a_spi_byte_gap: assert property (spi_sel_reg && $fell(lvl[PIN_DAT]) |-> gap_reg >= 16'h0316)
        else $error("spi bytes too close");
    a_tw_clk_high: assert property (!spi_sel_reg && $rose(lvl[PIN_CLK]) |-> lvl[PIN_CLK] [*8])
        else $error("two-wire clock high too short");
    a_stretch_drain: assert property (!spi_sel_reg && dev_oe[PIN_CLK] |-> !dev_o[PIN_CLK])
        else $error("clock stretch drives high");
endmodule

// >>> tb/host_port_select_tb.sv
`timescale 1ns/10ps
module host_port_select_tb;
    import host_port_pkg::*;
    logic clk_i, srst_i, strap_uart_i, uart_tx_valid_i, tw_sda_low_i, tw_busy_i;
    logic spi_valid_i, tw_valid_i, tw_cond_i, tw_bit_i, uart_tx_ready_o, uart_rx_valid_o;
    logic dev_rx_valid_o, mode_valid_o, spi_mode_o, tw_scl_o, tw_sda_o, spi_ready_o;
    logic host_rx_valid_o, tw_ready_o, tw_done_o, tw_rx_bit_o;
    logic [7:0] uart_tx_data_i, spi_tx_data_i, spi_data_i, uart_rx_data_o, dev_rx_data_o;
    logic [7:0] host_rx_data_o, b, m, s;
    logic [9:0] frame;
    cnt_t       baud_div_i;
    int         num_errors, compares, n;
    time        t0;

    host_port_if pins_if ();
    port_select_dev u_port_select_dev (.clk_i, .srst_i, .pins(pins_if), .baud_div_i,
        .uart_tx_valid_i, .uart_tx_data_i, .uart_tx_ready_o, .uart_rx_valid_o,
        .uart_rx_data_o, .spi_tx_data_i, .spi_rx_valid_o(dev_rx_valid_o),
        .spi_rx_data_o(dev_rx_data_o), .tw_scl_o, .tw_sda_o, .tw_sda_low_i, .tw_busy_i,
        .mode_valid_o, .spi_mode_o);
    port_select_host u_port_select_host (.clk_i, .srst_i, .pins(pins_if), .strap_uart_i,
        .spi_valid_i, .spi_data_i, .spi_ready_o, .spi_rx_valid_o(host_rx_valid_o),
        .spi_rx_data_o(host_rx_data_o), .tw_valid_i, .tw_cond_i, .tw_bit_i, .tw_ready_o,
        .tw_done_o, .tw_rx_bit_o);
    host_port_select_checker u_host_port_select_checker (.clk_i, .srst_i,
        .dev_o(pins_if.dev_o), .dev_oe(pins_if.dev_oe), .lvl(pins_if.lvl),
        .strap(pins_if.strap), .usb_dp_pullup(pins_if.usb_dp_pullup));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic final_report();
        $display("mismatches %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic expire(input string nm);
        num_errors++;
        $display("CHECK FAILED %s expected event seen timeout", nm);
        final_report();
    endtask

    // bounded wait, sampled at falling edges so one-cycle pulses are seen
    task automatic wait_for(input int which, input int lim);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++) begin
            @(negedge clk_i);
            case (which)
                0: seen = (uart_tx_ready_o === 1'b1);
                1: seen = (pins_if.lvl[PIN_TXD] === 1'b0);
                2: seen = (tw_ready_o === 1'b1);
                3: seen = (tw_done_o === 1'b1);
                4: seen = (spi_ready_o === 1'b1);
                5: seen = (host_rx_valid_o === 1'b1);
                default: seen = (mode_valid_o === 1'b1);
            endcase
        end
        if (!seen) expire("wait");
    endtask

    task automatic do_reset(input logic strap);
        strap_uart_i = strap;
        srst_i = 1'b1;
        repeat (16) @(negedge clk_i);
        srst_i = 1'b0;
        wait_for(6, 20);
        chk("spi_mode", {7'h0, ~strap}, {7'h0, spi_mode_o});
        chk("dp_pullup", 8'h01, {7'h0, pins_if.usb_dp_pullup});
    endtask

    task automatic tw_op(input logic c, input logic bt);
        wait_for(2, 50);
        tw_valid_i = 1'b1;
        tw_cond_i = c;
        tw_bit_i = bt;
        @(negedge clk_i);
        tw_valid_i = 1'b0;
        wait_for(3, 3000);
    endtask

    initial begin
        repeat (100000) @(posedge clk_i);
        expire("run");
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {srst_i, strap_uart_i, uart_tx_valid_i, tw_sda_low_i, tw_busy_i} = 5'h19;
        {spi_valid_i, tw_valid_i, tw_cond_i, tw_bit_i} = 4'h0;
        {uart_tx_data_i, spi_tx_data_i, spi_data_i} = 24'h0;
        baud_div_i = 16'h0004;
        num_errors = 0;
        compares = 0;
        n = $urandom(89);
        do_reset(1'b1);
        for (int k = 0; k < 4; k++) begin
            b = (k == 0) ? 8'hfe : 8'($urandom());
            baud_div_i = (k == 0) ? 16'h0004 : 16'h0004 + 16'($urandom_range(12));
            wait_for(0, 50);
            uart_tx_valid_i = 1'b1;
            uart_tx_data_i = b;
            @(negedge clk_i);
            uart_tx_valid_i = 1'b0;
            wait_for(1, 20);
            repeat (baud_div_i / 2) @(negedge clk_i);
            for (int i = 0; i < 10; i++) begin
                frame[i] = pins_if.lvl[PIN_TXD];
                repeat (baud_div_i) @(negedge clk_i);
            end
            chk("uart_data", b, frame[8:1]);
            chk("uart_framing", 8'h02, {6'h0, frame[9], frame[0]});
        end
        b = 8'($urandom());
        tw_op(1'b1, 1'b0);
        for (int i = 7; i >= 0; i--) begin
            tw_busy_i = (i == 4);
            t0 = $time;
            // only the stretched bit may drop busy, or an old release cuts it short
            if (i == 4) begin
                fork
                    begin
                        repeat (400) @(negedge clk_i);
                        tw_busy_i = 1'b0;
                    end
                join_none
            end
            tw_op(1'b0, b[i]);
            chk("tw_bit", {7'h0, b[i]}, {7'h0, tw_rx_bit_o});
            chk("tw_sda_seen", {7'h0, b[i]}, {7'h0, tw_sda_o});
            if (i == 4) chk("tw_stretch", 8'h01, {7'h0, ($time - t0) > 4000});
        end
        tw_sda_low_i = 1'b1;
        tw_op(1'b0, 1'b1);
        chk("tw_ack", 8'h00, {7'h0, tw_rx_bit_o});
        tw_sda_low_i = 1'b0;
        tw_op(1'b1, 1'b1);
        repeat (4) @(negedge clk_i);
        chk("tw_idle", 8'h03, {6'h0, tw_scl_o, tw_sda_o});
        strap_uart_i = 1'b0;
        repeat (50) @(negedge clk_i);
        chk("mode_held", 8'h03, {6'h0, mode_valid_o, ~spi_mode_o});
        do_reset(1'b0);
        tw_sda_low_i = 1'b1;
        for (int k = 0; k < 3; k++) begin
            m = (k == 0) ? 8'h80 : 8'($urandom());
            s = (k == 0) ? 8'h01 : 8'($urandom());
            spi_tx_data_i = s;
            wait_for(4, 1000);
            spi_valid_i = 1'b1;
            spi_data_i = m;
            @(negedge clk_i);
            spi_valid_i = 1'b0;
            wait_for(5, 300);
            chk("spi_mosi", m, dev_rx_data_o);
            chk("spi_miso", s, host_rx_data_o);
        end
        chk("tw_forced", 8'h03, {6'h0, tw_scl_o, tw_sda_o});
        final_report();
    end
endmodule
